// ==== verilog/qaw_answer_evaluator.v ====
// answer evaluator of a question-and-answer watchdog, multi-answer mode
// assumes window timing and answer checking outside; one clock, sync reset
// Operation
// - multi-answer evaluation runs only while config select is zero
// - three good in window one, one good in two: restart, decrement, new
// - four answers in window one: restart, increment, error, same question
// - four correct in window one keeps answer error clear
// - under four answers, window one only: wait window two end, fail
// - three wrong then one right: restart at fourth, both flags set
// - under three in window one, total four: restart at fourth, fail
// - two-bit answer count; below four at window two close fails cycle
// - failed cycle repeats the pending question
// - failure counter reaching limit triggers the watchdog action
`timescale 1ns/1ns
`include "qaw_defs.vh"

module qaw_answer_evaluator #(
    parameter FAIL_W = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire answer_valid,
    input wire answer_correct,
    input wire window2_active,
    input wire window2_end,
    output wire cycle_restart,
    output wire new_question,
    output reg repeat_question_ff,
    output reg watchdog_action_ff,
    output reg answer_error_flag_ff,
    output reg watchdog_error_flag_ff,
    output reg [1:0] answer_count_field_ff,
    output reg [FAIL_W-1:0] fail_count_ff,
    output wire irq,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    function known_ofs;
        input [7:0] a;
        begin
            known_ofs = (a == `QAW_CTRL_OFS) || (a == `QAW_STAT_OFS) ||
                (a == `QAW_IRQ_STAT_OFS) || (a == `QAW_IRQ_MASK_OFS);
        end
    endfunction

    reg cfg_select_ff;
    reg [FAIL_W-1:0] fail_limit_ff;
    reg [`QAW_IRQ_W-1:0] irq_stat_ff;
    reg [`QAW_IRQ_W-1:0] irq_mask_ff;
    reg [1:0] w1_count_ff;
    reg wrong_seen_ff;
    reg aw_held_ff;
    reg [7:0] aw_addr_ff;
    reg w_held_ff;
    reg [31:0] w_data_ff;
    reg [3:0] w_strb_ff;
    reg restart_ff;
    reg new_q_ff;

    wire mode_on;
    wire fourth;
    wire close_short;
    wire cycle_end;
    wire good;
    wire fail;
    wire aerr_now;
    wire hit_limit;
    wire wr_go;
    wire [7:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [`QAW_IRQ_W-1:0] irq_set;
    wire [`QAW_IRQ_W-1:0] irq_clr;

    assign mode_on = (cfg_select_ff == `QAW_MULTI_ANSWER);
    assign fourth = mode_on && answer_valid &&
        (answer_count_field_ff == `QAW_LAST_CNT);
    // a fourth answer in the close cycle wins over the window close
    assign close_short = mode_on && window2_end && !fourth;
    assign cycle_end = fourth || close_short;
    // good only with exactly three first-window answers, all correct
    assign good = fourth && window2_active && answer_correct &&
        !wrong_seen_ff && (w1_count_ff == `QAW_W1_GOOD);
    assign fail = cycle_end && !good;
    assign aerr_now = wrong_seen_ff ||
        (fourth && !answer_correct);
    assign hit_limit = fail &&
        (fail_count_ff == fail_limit_ff - 1'b1);

    assign cycle_restart = restart_ff;
    assign new_question = new_q_ff;

    // answer tracking within one watchdog cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            answer_count_field_ff <= 2'h0;
            w1_count_ff <= 2'h0;
            wrong_seen_ff <= 1'b0;
        end else if (ce) begin
            if (cycle_end || !mode_on) begin
                answer_count_field_ff <= 2'h0;
                w1_count_ff <= 2'h0;
                wrong_seen_ff <= 1'b0;
            end else if (answer_valid) begin
                answer_count_field_ff <=
                    answer_count_field_ff + 2'h1;
                if (!window2_active) begin
                    w1_count_ff <= w1_count_ff + 2'h1;
                end
                if (!answer_correct) begin
                    wrong_seen_ff <= 1'b1;
                end
            end
        end
    end

    // cycle outcome: flags, failure counter, question choice
    always @(posedge aclk) begin
        if (!aresetn) begin
            answer_error_flag_ff <= 1'b0;
            watchdog_error_flag_ff <= 1'b0;
            fail_count_ff <= {FAIL_W{1'b0}};
            repeat_question_ff <= 1'b0;
            watchdog_action_ff <= 1'b0;
            restart_ff <= 1'b0;
            new_q_ff <= 1'b0;
        end else if (ce) begin
            restart_ff <= cycle_end;
            new_q_ff <= good;
            watchdog_action_ff <= hit_limit;
            if (cycle_end) begin
                answer_error_flag_ff <= aerr_now;
                watchdog_error_flag_ff <= fail;
                repeat_question_ff <= fail;
                if (good) begin
                    if (fail_count_ff != {FAIL_W{1'b0}}) begin
                        fail_count_ff <= fail_count_ff - 1'b1;
                    end
                end else if (fail_count_ff < fail_limit_ff) begin
                    fail_count_ff <= fail_count_ff + 1'b1;
                end
            end
        end
    end

    // axi4-lite write: address and data taken in either order
    assign s_axi_awready = !aw_held_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_held_ff && !s_axi_bvalid;
    assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
    assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
    assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
    assign wr_go = !s_axi_bvalid && (aw_held_ff || s_axi_awvalid) &&
        (w_held_ff || s_axi_wvalid);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `QAW_RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                aw_held_ff <= 1'b0;
                w_held_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= known_ofs(wr_addr) ? `QAW_RESP_OKAY :
                    `QAW_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    aw_held_ff <= 1'b1;
                    aw_addr_ff <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    w_held_ff <= 1'b1;
                    w_data_ff <= s_axi_wdata;
                    w_strb_ff <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // control and mask registers, low byte lane only
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_select_ff <= `QAW_CFG_RST;
            fail_limit_ff <= `QAW_LIM_RST;
            irq_mask_ff <= `QAW_MASK_RST;
        end else if (ce && wr_go && wr_strb[0]) begin
            if (wr_addr == `QAW_CTRL_OFS) begin
                cfg_select_ff <= wr_data[`QAW_CTRL_CFG_BIT];
                fail_limit_ff <=
                    wr_data[`QAW_CTRL_LIM_MSB:`QAW_CTRL_LIM_LSB];
            end
            if (wr_addr == `QAW_IRQ_MASK_OFS) begin
                irq_mask_ff <= wr_data[`QAW_IRQ_W-1:0];
            end
        end
    end

    // sticky events, write one to clear, a new event wins over the clear
    assign irq_set = {hit_limit, fail, good};
    assign irq_clr = (wr_go && wr_strb[0] &&
        (wr_addr == `QAW_IRQ_STAT_OFS)) ? wr_data[`QAW_IRQ_W-1:0] :
        {`QAW_IRQ_W{1'b0}};

    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_ff <= {`QAW_IRQ_W{1'b0}};
        end else if (ce) begin
            irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_stat_ff & irq_mask_ff);

    // axi4-lite read, answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `QAW_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= known_ofs(s_axi_araddr) ? `QAW_RESP_OKAY :
                    `QAW_RESP_SLVERR;
                s_axi_rdata <= 32'h0000_0000;
                case (s_axi_araddr)
                    `QAW_CTRL_OFS: begin
                        s_axi_rdata[`QAW_CTRL_CFG_BIT] <= cfg_select_ff;
                        s_axi_rdata[`QAW_CTRL_LIM_MSB:`QAW_CTRL_LIM_LSB] <=
                            fail_limit_ff;
                    end
                    `QAW_STAT_OFS: begin
                        s_axi_rdata[`QAW_STAT_CNT_MSB:`QAW_STAT_CNT_LSB] <=
                            answer_count_field_ff;
                        s_axi_rdata[`QAW_STAT_AERR_BIT] <=
                            answer_error_flag_ff;
                        s_axi_rdata[`QAW_STAT_WERR_BIT] <=
                            watchdog_error_flag_ff;
                        s_axi_rdata[`QAW_STAT_FAIL_MSB:`QAW_STAT_FAIL_LSB] <=
                            fail_count_ff;
                        s_axi_rdata[`QAW_STAT_RPT_BIT] <= repeat_question_ff;
                    end
                    `QAW_IRQ_STAT_OFS: begin
                        s_axi_rdata[`QAW_IRQ_W-1:0] <= irq_stat_ff;
                    end
                    `QAW_IRQ_MASK_OFS: begin
                        s_axi_rdata[`QAW_IRQ_W-1:0] <= irq_mask_ff;
                    end
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // qaw_answer_evaluator

// ==== verilog/qaw_defs.vh ====
// constants for the question-and-answer watchdog answer evaluator
// included by the evaluator top; holds definitions only
`ifndef QAW_DEFS_VH
`define QAW_DEFS_VH

// register byte offsets
`define QAW_CTRL_OFS 8'h00
`define QAW_STAT_OFS 8'h04
`define QAW_IRQ_STAT_OFS 8'h08
`define QAW_IRQ_MASK_OFS 8'h0C

// control register fields
`define QAW_CTRL_CFG_BIT 0
`define QAW_CTRL_LIM_LSB 4
`define QAW_CTRL_LIM_MSB 7

// status register fields
`define QAW_STAT_CNT_LSB 0
`define QAW_STAT_CNT_MSB 1
`define QAW_STAT_AERR_BIT 2
`define QAW_STAT_WERR_BIT 3
`define QAW_STAT_FAIL_LSB 4
`define QAW_STAT_FAIL_MSB 7
`define QAW_STAT_RPT_BIT 8

// interrupt bits
`define QAW_IRQ_OK_BIT 0
`define QAW_IRQ_FAIL_BIT 1
`define QAW_IRQ_ACT_BIT 2
`define QAW_IRQ_W 3

// reset values and the multi-answer select code
`define QAW_CFG_RST 1'b0
`define QAW_MULTI_ANSWER 1'b0
`define QAW_LIM_RST 4'hF
`define QAW_MASK_RST 3'h0

// answer count value of the fourth answer and first-window answers of a good sequence
`define QAW_W1_GOOD 2'h3
`define QAW_LAST_CNT 2'h3

// axi responses
`define QAW_RESP_OKAY 2'b00
`define QAW_RESP_SLVERR 2'b10

`endif

// ==== verification/qaw_eval_sva.sv ====
// assertions on the answer evaluator outputs
// bound to the evaluator; one clock, sync active-low reset
`timescale 1ns/1ns
module qaw_eval_sva #(parameter FAIL_W = 4) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic answer_valid,
    input wire logic window2_end,
    input wire logic cycle_restart,
    input wire logic new_question,
    input wire logic repeat_question_ff,
    input wire logic answer_error_flag_ff,
    input wire logic watchdog_error_flag_ff,
    input wire logic [1:0] answer_count_field_ff,
    input wire logic [FAIL_W-1:0] fail_count_ff
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
a_good_restart: assert property (new_question |-> cycle_restart)
    else $error("new question without restart");
a_good_flags: assert property (new_question |-> !answer_error_flag_ff &&
    !watchdog_error_flag_ff && !repeat_question_ff)
    else $error("flags set on good cycle");
a_good_dec: assert property (new_question |-> fail_count_ff ==
    ($past(fail_count_ff) == 0 ? 0 : $past(fail_count_ff) - 1))
    else $error("fail count not decremented");
a_fail_flags: assert property (cycle_restart && !new_question |->
    watchdog_error_flag_ff && repeat_question_ff)
    else $error("failed cycle flags wrong");
a_fail_inc: assert property (cycle_restart && !new_question |->
    fail_count_ff == $past(fail_count_ff) + 1 ||
    fail_count_ff == $past(fail_count_ff))
    else $error("fail count not incremented");
a_fourth_ends: assert property (answer_valid &&
    answer_count_field_ff == 2'h3 |=> cycle_restart)
    else $error("fourth answer did not end cycle");
a_close_ends: assert property (window2_end |=> cycle_restart)
    else $error("window close did not end cycle");
a_count_clear: assert property (cycle_restart |->
    answer_count_field_ff == 2'h0)
    else $error("count not cleared at restart");
a_restart_cause: assert property (cycle_restart |->
    $past(answer_valid || window2_end))
    else $error("restart without cause");
endmodule // qaw_eval_sva

bind qaw_answer_evaluator qaw_eval_sva #(.FAIL_W(FAIL_W)) u_sva(.*);

// ==== verification/qaw_host_model.sv ====
// host that writes watchdog answers and drives the window timing
// tasks are called by the bench; drives after rising edges
`timescale 1ns/1ns
module qaw_host_model (
    input wire logic aclk,
    output logic answer_valid,
    output logic answer_correct,
    output logic window2_active,
    output logic window2_end
);
initial {answer_valid, answer_correct, window2_active, window2_end} = 0;
// one answer byte; qualifier turns over once the pulse is gone
task give(input bit ok);
    @(posedge aclk);
    answer_valid <= 1;
    answer_correct <= ok;
    @(posedge aclk);
    answer_valid <= 0;
    answer_correct <= !ok;
endtask
task win2(input bit on);
    @(posedge aclk);
    window2_active <= on;
endtask
task close2;
    @(posedge aclk);
    window2_end <= 1;
    @(posedge aclk);
    window2_end <= 0;
    window2_active <= 0;
endtask
endmodule // qaw_host_model

// ==== verification/qaw_answer_evaluator_tb.sv ====
// self-checking bench for the answer evaluator
// host model drives answers; registers reached over axi4-lite
`timescale 1ns/1ns
module qaw_answer_evaluator_tb;
logic aclk = 0, aresetn = 0, ce = 1;
logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0;
logic [3:0] s_axi_wstrb = 4'hF;
logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
logic s_axi_arvalid = 0, s_axi_rready = 0;
wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
wire s_axi_rvalid, answer_valid, answer_correct, window2_active;
wire window2_end, cycle_restart, new_question, repeat_question_ff;
wire watchdog_action_ff, answer_error_flag_ff, watchdog_error_flag_ff;
wire irq;
wire [1:0] s_axi_bresp, s_axi_rresp, answer_count_field_ff;
wire [3:0] fail_count_ff;
wire [31:0] s_axi_rdata;
int fails = 0, total_checks = 0, restarts = 0, acts = 0, ef = 0, nqs = 0;
logic [31:0] q;
logic [1:0] r;
qaw_answer_evaluator #(.FAIL_W(4)) DUT(.*);
qaw_host_model host(.*);
always #5 aclk = ~aclk;
always @(posedge aclk) begin
    restarts += (cycle_restart === 1'b1);
    acts += (watchdog_action_ff === 1'b1);
    nqs += (new_question === 1'b1);
end
task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
        fails++;
        $display("mismatch %s expected %h seen %h", n, e, g);
    end
endtask
task xfer(input bit w, input [7:0] a, input [31:0] d);
    int n;
    bit ao, wo, bo;
    @(posedge aclk);
    if (w) begin
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    end else begin
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
    end
    n = 0;
    bo = 0;
    while (!bo && n < 50) begin
        @(negedge aclk);
        ao = s_axi_awvalid && s_axi_awready || s_axi_arvalid && s_axi_arready;
        wo = s_axi_wvalid && s_axi_wready;
        bo = s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready;
        r = w ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        @(posedge aclk);
        if (ao) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
        if (wo) s_axi_wvalid <= 0;
        if (bo) {s_axi_bready, s_axi_rready} <= 2'h0;
        n++;
    end
    if (!bo) begin
        fails++;
        summarize;
    end
endtask
function [31:0] sv(bit rp, int f, bit we, bit ae);
    return {23'h0, rp, f[3:0], we, ae, 2'h0};
endfunction
task st(input [31:0] e);
    xfer(0, 8'h04, 0);
    chk("status", e, q);
endtask
task cyc(int n1, bit [3:0] ok1, int n2, bit [3:0] ok2, bit cl);
    for (int i = 0; i < n1; i++) host.give(ok1[i]);
    host.win2(1);
    for (int i = 0; i < n2; i++) host.give(ok2[i]);
    if (cl) host.close2;
    else host.win2(0);
    repeat (2) @(posedge aclk);
endtask
task s_good;
    int n0;
    n0 = nqs;
    cyc(3, 4'hF, 1, 4'h1, 0);
    ef = ef > 0 ? ef - 1 : 0;
    st(sv(0, ef, 0, 0));
    chk("new question", n0 + 1, nqs);
endtask
task s_w1_four;
    cyc(4, 4'hF, 0, 0, 0);
    st(sv(1, ++ef, 1, 0));
endtask
task s_wrong3;
    int n0;
    n0 = nqs;
    cyc(3, 4'h0, 1, 4'h1, 0);
    st(sv(1, ++ef, 1, 1));
    chk("new question", n0, nqs);
endtask
task s_short;
    int r0;
    r0 = restarts;
    cyc(2, 4'h3, 0, 0, 1);
    st(sv(1, ++ef, 1, 0));
    chk("restarts", r0 + 1, restarts);
endtask
task s_split;
    cyc(1, 4'h1, 3, 4'h7, 0);
    st(sv(1, ++ef, 1, 0));
endtask
task s_limit;
    int a0;
    a0 = acts;
    xfer(1, 8'h00, 32'h0000_0040);
    s_short;
    chk("action", a0 + 1, acts);
    xfer(1, 8'h0C, 32'h0000_0007);
    chk("irq", 1, irq);
    xfer(1, 8'h08, 32'h0000_0007);
    chk("irq", 0, irq);
    xfer(0, 8'h08, 0);
    chk("irq status", 0, q);
    xfer(0, 8'h10, 0);
    chk("unmapped resp", 2'h2, r);
endtask
task s_cfg;
    int r0;
    r0 = restarts;
    ce <= 0;
    host.give(1);
    ce <= 1;
    st(sv(1, ef, 1, 0));
    xfer(1, 8'h00, 32'h0000_0041);
    repeat (4) host.give(1);
    repeat (2) @(posedge aclk);
    chk("restarts", r0, restarts);
    st(sv(1, ef, 1, 0));
endtask
task summarize;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
endtask
initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    s_good;
    s_w1_four;
    s_wrong3;
    s_short;
    s_split;
    s_good;
    s_limit;
    s_cfg;
    summarize;
end
initial begin
    #200000;
    fails++;
    summarize;
end
endmodule // qaw_answer_evaluator_tb
